// ===== shared/lmsc_pkg.sv
/*
  lmsc_pkg: constants shared by both ends of the serial led matrix link.
  assumes: host on a 100 MHz clk, device on the link clock.
*/
package lmsc_pkg;
  // frame geometry
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int ID_W = 3;
  localparam int CMD_W = 9;
  localparam int RAM_DEPTH = 128;
  // mode identifiers
  localparam logic [2:0] ID_READ = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD = 3'h4;
  // command codes, upper eight bits of the nine-bit word
  localparam logic [7:0] CMD_SYS_HALT = 8'h00;
  localparam logic [7:0] CMD_OSC_START = 8'h01;
  localparam logic [7:0] CMD_DRIVE_OFF = 8'h02;
  localparam logic [7:0] CMD_DRIVE_ON = 8'h03;
  localparam logic [7:0] CMD_FLASH_OFF = 8'h08;
  localparam logic [7:0] CMD_FLASH_ON = 8'h09;
  localparam logic [7:0] CMD_FOLLOWER = 8'b0001_0???;
  localparam logic [7:0] CMD_INT_LEADER = 8'b0001_10??;
  localparam logic [7:0] CMD_EXT_LEADER = 8'b0001_11??;
  localparam logic [7:0] CMD_CATHODE = 8'b0010_????;
  localparam logic [7:0] CMD_DIMMING = 8'b101?_????;
  // cascade clocking modes
  localparam logic [1:0] CASC_FOLLOWER = 2'h0;
  localparam logic [1:0] CASC_INT_LEADER = 2'h1;
  localparam logic [1:0] CASC_EXT_LEADER = 2'h2;
  // reset values of the configuration
  localparam logic RST_OSC_RUN = 1'h0;
  localparam logic RST_DISPLAY_RUN = 1'h0;
  localparam logic RST_BLINK = 1'h0;
  localparam logic [1:0] RST_CASCADE = CASC_INT_LEADER;
  localparam logic [1:0] RST_CATHODE = 2'h0;
  localparam logic [3:0] RST_DIM = 4'hF;
  // host strobe timing
  localparam int CLK_NS = 10;
  localparam int STROBE_HALF_NS = 1000;
  localparam int STROBE_HALF_CYC = (STROBE_HALF_NS + CLK_NS - 1) / CLK_NS;
  // host request kinds
  typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_RMW, KIND_CMD} lmsc_kind_e;
endpackage

// ===== shared/lmsc_if.sv
/*
  lmsc_if: the four-wire serial link between host and device.
  assumes: bench drives lclk; data line is pulled high when nobody drives it.
*/
interface lmsc_if (
  // link clock from the bench
  input wire logic lclk
);
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic data;

  // resolved level of the shared data line, pull-up when idle
  assign data = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 1'b1);

  modport host (
    output cs_n, wr_n, rd_n, host_data_o, host_data_oe,
    input data
  );
  modport dev (
    input lclk, cs_n, wr_n, rd_n, data,
    output dev_data_o, dev_data_oe
  );
endinterface

// ===== rtl/lmsc_host.sv
/*
  lmsc_host: host end; turns user requests into strobed serial frames.
  assumes: device samples strobes on a slower clock; a half strobe period
  of about 1 us leaves it several link cycles per edge.
*/
module lmsc_host #(
  parameter int HALF_CYC = lmsc_pkg::STROBE_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link
  lmsc_if.host link,
  // request
  input wire logic req_valid,
  input wire lmsc_pkg::lmsc_kind_e req_kind,
  input wire logic [6:0] req_addr,
  input wire logic [3:0] req_data,
  input wire logic [8:0] req_cmd,
  input wire logic req_chain,
  // answer
  output logic req_ready,
  output logic done,
  output logic [3:0] rd_data
);
  typedef enum {H_IDLE, H_CSH, H_LEAD, H_NEXT, H_WR, H_RD, H_END} lmsc_hst_e;

  if (HALF_CYC < 1 || HALF_CYC > 255) $error("HALF_CYC out of range");

  lmsc_hst_e st;
  logic [7:0] timer;
  logic hi;
  logic [13:0] tx;
  logic [3:0] tx_cnt;
  logic [2:0] rd_cnt;
  logic [1:0] ridx;
  logic w2_pend;
  logic [3:0] w2_data;
  logic chain_q;
  logic chained_now;
  logic req_chain_hold;
  lmsc_pkg::lmsc_kind_e last_kind;
  logic [2:0] dsync;
  logic data_st;
  logic tick;

  // data nibbles travel lowest bit first
  function automatic logic [3:0] rev4(input logic [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction

  // the data line belongs to the device clock, so three flops before use
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      dsync <= 3'h7;
      data_st <= 1'h1;
    end
    else
    begin
      dsync <= {dsync[1:0], link.data};
      if (dsync[1] == dsync[2])
        data_st <= dsync[2];
    end

  assign tick = (timer == 8'(HALF_CYC - 1));
  assign chained_now = chain_q && (last_kind == req_kind); // [R17] [R21]

  // frame sequencer
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      st <= H_IDLE;
      timer <= 8'h00;
      hi <= 1'h0;
      tx <= 14'h0000;
      tx_cnt <= 4'h0;
      rd_cnt <= 3'h0;
      ridx <= 2'h0;
      w2_pend <= 1'h0;
      w2_data <= 4'h0;
      chain_q <= 1'h0;
      last_kind <= lmsc_pkg::KIND_READ;
      link.cs_n <= 1'h1;
      link.wr_n <= 1'h1;
      link.rd_n <= 1'h1;
      link.host_data_o <= 1'h0;
      link.host_data_oe <= 1'h0;
      req_ready <= 1'h0;
      done <= 1'h0;
      rd_data <= 4'h0;
    end
    else
    begin
      done <= 1'h0;
      case (st)
        H_IDLE:
        begin
          req_ready <= 1'h1;
          if (req_valid && req_ready)
          begin
            req_ready <= 1'h0;
            last_kind <= req_kind;
            ridx <= 2'h0;
            w2_data <= req_data;
            w2_pend <= (req_kind == lmsc_pkg::KIND_RMW); // [R3]
            rd_cnt <= (req_kind == lmsc_pkg::KIND_READ || req_kind == lmsc_pkg::KIND_RMW) ? 3'h4 : 3'h0;
            st <= chained_now ? H_NEXT : H_CSH;
            timer <= 8'h00;
            case (req_kind)
              lmsc_pkg::KIND_WRITE:
              begin
                tx <= chained_now ? {rev4(req_data), 10'h000} : {lmsc_pkg::ID_WRITE, req_addr, rev4(req_data)}; // [R2]
                tx_cnt <= chained_now ? 4'h4 : 4'hE;
              end
              lmsc_pkg::KIND_CMD:
              begin
                tx <= chained_now ? {req_cmd, 5'h00} : {lmsc_pkg::ID_CMD, req_cmd, 2'h0}; // [R22]
                tx_cnt <= chained_now ? 4'h9 : 4'hC;
              end
              lmsc_pkg::KIND_READ:
              begin
                tx <= {lmsc_pkg::ID_READ, req_addr, 4'h0}; // [R1]
                tx_cnt <= chained_now ? 4'h0 : 4'hA;
              end
              default:
              begin
                tx <= {lmsc_pkg::ID_WRITE, req_addr, 4'h0}; // [R3]
                tx_cnt <= chained_now ? 4'h0 : 4'hA;
              end
            endcase
          end
        end
        H_CSH:
        begin
          // high pulse restarts the device interface
          link.cs_n <= 1'h1; // [R20]
          timer <= tick ? 8'h00 : timer + 8'h01;
          if (tick)
          begin
            link.cs_n <= 1'h0;
            st <= H_LEAD;
          end
        end
        H_LEAD:
        begin
          timer <= tick ? 8'h00 : timer + 8'h01;
          if (tick)
            st <= H_NEXT;
        end
        H_NEXT:
        begin
          timer <= 8'h00;
          hi <= 1'h0;
          if (tx_cnt != 4'h0)
          begin
            st <= H_WR;
            link.wr_n <= 1'h0;
            link.host_data_o <= tx[13];
            link.host_data_oe <= 1'h1;
          end
          else if (rd_cnt != 3'h0)
          begin
            st <= H_RD;
            link.rd_n <= 1'h0;
            link.host_data_oe <= 1'h0;
          end
          else if (w2_pend)
          begin
            w2_pend <= 1'h0;
            tx <= {rev4(w2_data), 10'h000};
            tx_cnt <= 4'h4;
          end
          else
          begin
            st <= H_END;
            link.host_data_oe <= 1'h0;
          end
        end
        H_WR:
        begin
          timer <= tick ? 8'h00 : timer + 8'h01;
          if (tick && !hi)
          begin
            hi <= 1'h1;
            link.wr_n <= 1'h1;
          end
          else if (tick)
          begin
            tx <= {tx[12:0], 1'h0};
            tx_cnt <= tx_cnt - 4'h1;
            st <= H_NEXT;
          end
        end
        H_RD:
        begin
          timer <= tick ? 8'h00 : timer + 8'h01;
          if (tick && !hi)
          begin
            // sample just before the rising edge, data settled long before
            hi <= 1'h1;
            link.rd_n <= 1'h1;
            rd_data[ridx] <= data_st;
            ridx <= ridx + 2'h1;
          end
          else if (tick)
          begin
            rd_cnt <= rd_cnt - 3'h1;
            st <= H_NEXT;
          end
        end
        H_END:
        begin
          done <= 1'h1;
          chain_q <= req_chain_hold;
          if (!req_chain_hold)
            link.cs_n <= 1'h1; // [R20]
          st <= H_IDLE;
        end
        default:
          st <= H_IDLE;
      endcase
    end

  // chain request is latched at acceptance so the user may drop it
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      req_chain_hold <= 1'h0;
    else if (st == H_IDLE && req_valid && req_ready)
      req_chain_hold <= req_chain;
endmodule

// ===== rtl/lmsc_device.sv
/*
  lmsc_device: device end; serial frame decoder, nibble ram and configuration.
  assumes: runs on the link clock; strobes and data arrive asynchronously and
  each strobe half lasts several link clock periods.
*/
// Function
// [R1] read frame: 110, address, nibble out
// [R2] write frame: 101, address, nibble stored
// [R3] read-modify-write shares 101, read then write
// [R4] system_halt stops oscillator and display
// [R5] osc_start starts the oscillator
// [R6] display_drive_off disables display, reset default
// [R7] display_drive_on enables the display
// [R8] flash_disable stops blinking, reset default
// [R9] flash_enable blinks the whole display
// [R10] follower_setting takes clock and timing in
// [R11] internal_osc_leader drives both pins, default
// [R12] external_timebase_leader: clock in, timing out
// [R13] cathode_line_config selects drive type, commons
// [R14] dimming_level sets duty (p+1)/16
// [R15] host makes one leader, rest followers
// [R16] host gives each device own select
// [R17] successive commands may omit command id
// [R18] bits sampled at write strobe rise
// [R19] read bit driven at read strobe fall
// [R20] select high aborts, new id needed
// [R21] address increments after each nibble
// [R22] commands nine bits, last one ignored
module lmsc_device #(
  parameter int ADDR_W = lmsc_pkg::ADDR_W
) (
  // link, clocked by its own clock
  lmsc_if.dev link,
  // reset of the link domain
  input wire logic rstn,
  // display scan read port
  input wire logic [6:0] scan_addr,
  output logic [3:0] scan_data,
  // configuration
  output logic osc_run,
  output logic display_run,
  output logic blink_en,
  output logic [1:0] cascade_mode,
  output logic shared_clock_oe,
  output logic cascade_timing_oe,
  output logic [1:0] cathode_cfg,
  output logic [3:0] dim_level
);
  typedef enum {S_ID, S_ADDR, S_DATA, S_CMD, S_SKIP} lmsc_dst_e;
  if (ADDR_W != lmsc_pkg::ADDR_W) $error("ADDR_W must match the 7-bit frame address");
  // index 0 cs_n, 1 wr_n, 2 rd_n, 3 data
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;
  logic [3:0] stab;
  logic [3:0] stab_q;
  logic cs_hi;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic din;
  lmsc_dst_e st;
  logic [3:0] cnt;
  logic [7:0] shift;
  logic [6:0] addr;
  logic is_read;
  logic [1:0] wbit;
  logic [1:0] rbit;
  logic [2:0] wnib;
  logic ram_we;
  logic cmd_fire;
  logic [7:0] cmd_word;
  logic [3:0] ram [lmsc_pkg::RAM_DEPTH];

  // three flops per pin; a level counts once the second and third agree
  always_ff @(posedge link.lclk or negedge rstn)
    if (!rstn)
    begin
      s1 <= 4'hF;
      s2 <= 4'hF;
      s3 <= 4'hF;
      stab <= 4'hF;
      stab_q <= 4'hF;
    end
    else
    begin
      s1 <= {link.data, link.rd_n, link.wr_n, link.cs_n};
      s2 <= s1;
      s3 <= s2;
      stab <= (s2 & s3) | (stab & (s2 ^ s3));
      stab_q <= stab;
    end

  // strobe edges seen on the filtered levels
  assign cs_hi = stab[0];
  assign wr_rise = stab[1] && !stab_q[1]; // [R18]
  assign rd_fall = !stab[2] && stab_q[2]; // [R19]
  assign rd_rise = stab[2] && !stab_q[2];
  assign din = stab[3];
  // ram write on the fourth data bit, command on the ninth bit
  assign ram_we = !cs_hi && wr_rise && st == S_DATA && !is_read && wbit == 2'h3; // [R2]
  assign cmd_fire = !cs_hi && wr_rise && st == S_CMD && cnt == 4'h8; // [R22]
  assign cmd_word = shift; // ninth bit is don't-care
  // frame decoder
  always_ff @(posedge link.lclk or negedge rstn)
    if (!rstn)
    begin
      st <= S_ID;
      cnt <= 4'h0;
      shift <= 8'h00;
      addr <= 7'h00;
      is_read <= 1'h0;
      wbit <= 2'h0;
      rbit <= 2'h0;
      wnib <= 3'h0;
    end
    else if (cs_hi)
    begin
      // select high drops whatever mode was active
      st <= S_ID; // [R20]
      cnt <= 4'h0;
      wbit <= 2'h0;
      rbit <= 2'h0;
    end
    else if (wr_rise)
    begin
      case (st)
        S_ID:
        begin
          shift <= {shift[6:0], din};
          cnt <= cnt + 4'h1;
          if (cnt == 4'h2)
          begin
            cnt <= 4'h0;
            if ({shift[1:0], din} == lmsc_pkg::ID_READ)
            begin
              is_read <= 1'h1; // [R1]
              st <= S_ADDR;
            end
            else if ({shift[1:0], din} == lmsc_pkg::ID_WRITE)
            begin
              is_read <= 1'h0; // [R2] [R3]
              st <= S_ADDR;
            end
            else if ({shift[1:0], din} == lmsc_pkg::ID_CMD)
              st <= S_CMD;
            else
              st <= S_SKIP; // unknown id waits for select high
          end
        end
        S_ADDR:
        begin
          addr <= {addr[5:0], din}; // highest bit first
          cnt <= cnt + 4'h1;
          if (cnt == 4'h6)
          begin
            cnt <= 4'h0;
            st <= S_DATA;
          end
        end
        S_DATA:
        begin
          // write bits arrive lowest first; a read frame ignores them
          if (!is_read)
          begin
            wnib[wbit] <= din;
            wbit <= wbit + 2'h1;
            if (wbit == 2'h3)
            begin
              addr <= addr + 7'h01; // [R21]
              rbit <= 2'h0;
            end
          end
        end
        S_CMD:
        begin
          // stays in command mode, so later commands need no id
          shift <= {shift[6:0], din};
          cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1; // [R17] [R22]
        end
        default:
          st <= S_SKIP;
      endcase
    end
    else if (rd_rise && st == S_DATA)
    begin
      rbit <= rbit + 2'h1;
      if (rbit == 2'h3 && is_read)
        addr <= addr + 7'h01; // [R21]
    end

  // nibble store; no reset, contents are undefined until written
  always_ff @(posedge link.lclk)
    if (ram_we)
      ram[addr] <= {din, wnib}; // [R2] [R3]
  // scan port runs on the link clock as well
  always_ff @(posedge link.lclk or negedge rstn)
    if (!rstn)
      scan_data <= 4'h0;
    else
      scan_data <= ram[scan_addr];
  // data line driver; released after the fourth bit so the host may write
  always_ff @(posedge link.lclk or negedge rstn)
    if (!rstn)
    begin
      link.dev_data_o <= 1'h0;
      link.dev_data_oe <= 1'h0;
    end
    else if (cs_hi)
      link.dev_data_oe <= 1'h0; // [R20]
    else if (rd_fall && st == S_DATA)
    begin
      link.dev_data_o <= ram[addr][rbit]; // [R1] [R3] [R19]
      link.dev_data_oe <= 1'h1;
    end
    else if (rd_rise && rbit == 2'h3)
      link.dev_data_oe <= 1'h0;
  // configuration commands
  always_ff @(posedge link.lclk or negedge rstn)
    if (!rstn)
    begin
      osc_run <= lmsc_pkg::RST_OSC_RUN;
      display_run <= lmsc_pkg::RST_DISPLAY_RUN; // [R6]
      blink_en <= lmsc_pkg::RST_BLINK; // [R8]
      cascade_mode <= lmsc_pkg::RST_CASCADE; // [R11]
      shared_clock_oe <= 1'h1;
      cascade_timing_oe <= 1'h1;
      cathode_cfg <= lmsc_pkg::RST_CATHODE; // [R13]
      dim_level <= lmsc_pkg::RST_DIM;
    end
    else if (cmd_fire)
    begin
      casez (cmd_word)
        lmsc_pkg::CMD_SYS_HALT:
        begin
          osc_run <= 1'h0; // [R4]
          display_run <= 1'h0;
        end
        lmsc_pkg::CMD_OSC_START:
          osc_run <= 1'h1; // [R5]
        lmsc_pkg::CMD_DRIVE_OFF:
          display_run <= 1'h0; // [R6]
        lmsc_pkg::CMD_DRIVE_ON:
          display_run <= 1'h1; // [R7]
        lmsc_pkg::CMD_FLASH_OFF:
          blink_en <= 1'h0; // [R8]
        lmsc_pkg::CMD_FLASH_ON:
          blink_en <= 1'h1; // [R9]
        lmsc_pkg::CMD_FOLLOWER:
        begin
          cascade_mode <= lmsc_pkg::CASC_FOLLOWER; // [R10] [R15]
          shared_clock_oe <= 1'h0;
          cascade_timing_oe <= 1'h0;
        end
        lmsc_pkg::CMD_INT_LEADER:
        begin
          cascade_mode <= lmsc_pkg::CASC_INT_LEADER; // [R11]
          shared_clock_oe <= 1'h1;
          cascade_timing_oe <= 1'h1;
        end
        lmsc_pkg::CMD_EXT_LEADER:
        begin
          cascade_mode <= lmsc_pkg::CASC_EXT_LEADER; // [R12]
          shared_clock_oe <= 1'h0;
          cascade_timing_oe <= 1'h1;
        end
        lmsc_pkg::CMD_CATHODE:
          cathode_cfg <= cmd_word[3:2]; // [R13]
        lmsc_pkg::CMD_DIMMING:
          dim_level <= cmd_word[3:0]; // [R14] duty is (p+1)/16
        default: ; // unlisted codes change nothing
      endcase
    end
endmodule

// ===== sim/lmsc_properties.sv
/*
  lmsc_properties: link-level checks on the four serial wires.
  assumes: sampled on the link clock; rstn is the link reset, active low.
*/
module lmsc_properties (
  // link domain
  input wire logic lclk,
  input wire logic rstn,
  // link wires
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge lclk);
  endclocking
  default disable iff (!rstn);

  // the pull-up only works if at most one end drives the line
  one_driver_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data line");
  // a read strobe never overlaps a write strobe
  strobe_excl_a: assert property (!(!wr_n && !rd_n))
    else $error("read and write strobes low together");
  // the host must hold data across the write strobe rise
  wr_data_held_a: assert property ($rose(wr_n) && !cs_n |-> host_data_oe)
    else $error("write strobe rose with data undriven");
  // host lets go of the line while the device answers
  host_quiet_a: assert property (!rd_n |-> !host_data_oe)
    else $error("host drives data during read strobe");
  // the device answers within a few link cycles of the read fall
  read_answer_a: assert property ($fell(rd_n) && !cs_n |-> ##[2:6] dev_data_oe)
    else $error("device did not drive after read strobe fall");
  // the device only starts driving because of a read strobe
  answer_cause_a: assert property ($rose(dev_data_oe) |-> !$past(rd_n, 2))
    else $error("device drove data without a read strobe");
  // a deselected device must have released the line
  select_abort_a: assert property (cs_n [*6] |-> !dev_data_oe)
    else $error("device drives data while deselected");
  // no strobe while deselected, a frame needs select first
  idle_strobes_a: assert property (cs_n |-> wr_n && rd_n)
    else $error("strobe active while deselected");
endmodule

// ===== sim/lmsc_bench.sv
/*
  lmsc_bench: host and device joined over the link, random and corner frames.
  assumes: host on 100 MHz clk, device on a 160 ns link clock.
*/
module lmsc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // code and don't-care mask of each command sent
  localparam logic [15:0] CMD_TAB [15] = '{16'h0100, 16'h0300, 16'h0000, 16'h0100, 16'h0300,
    16'h0200, 16'h0900, 16'h0800, 16'h1007, 16'h1C03, 16'h1803, 16'h200F, 16'hA010, 16'hA01F, 16'h0400};
  logic clk, lclk, rstn, rstn_l, req_valid, req_chain, req_ready, done;
  lmsc_pkg::lmsc_kind_e req_kind;
  logic [6:0] req_addr, scan_addr;
  logic [3:0] req_data, rd_data, scan_data, dim_level;
  logic [8:0] req_cmd;
  logic osc_run, display_run, blink_en, shared_clock_oe, cascade_timing_oe;
  logic [1:0] cascade_mode, cathode_cfg;
  logic [3:0] exp_ram [128];
  int n_mismatch = 0;
  int checks_done = 0;
  wire logic [12:0] seen_cfg = {osc_run, display_run, blink_en, cascade_mode, shared_clock_oe,
    cascade_timing_oe, cathode_cfg, dim_level};

  lmsc_if link (.lclk(lclk)); // this device alone on its own select line
  // half strobe must outlast the device's answer delay of up to five link cycles plus the host sync
  lmsc_host #(.HALF_CYC(lmsc_pkg::STROBE_HALF_CYC)) i_lmsc_host (.clk(clk), .rstn(rstn), .link(link),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data), .req_cmd(req_cmd),
    .req_chain(req_chain), .req_ready(req_ready), .done(done), .rd_data(rd_data));
  lmsc_device i_lmsc_device (.link(link), .rstn(rstn_l), .scan_addr(scan_addr), .scan_data(scan_data),
    .osc_run(osc_run), .display_run(display_run), .blink_en(blink_en), .cascade_mode(cascade_mode),
    .shared_clock_oe(shared_clock_oe), .cascade_timing_oe(cascade_timing_oe),
    .cathode_cfg(cathode_cfg), .dim_level(dim_level));
  lmsc_properties i_props (.lclk(lclk), .rstn(rstn_l), .cs_n(link.cs_n), .wr_n(link.wr_n),
    .rd_n(link.rd_n), .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe));

  // system clock, 10 ns
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // link clock, 160 ns, offset so its edges never meet clk
  initial
  begin
    lclk = 1'b0;
    #3.7;
    forever #80 lclk = ~lclk;
  end

  // expected configuration after one command word
  function automatic logic [12:0] next_cfg(logic [12:0] s, logic [7:0] c);
    casez (c)
      lmsc_pkg::CMD_SYS_HALT: s[12:11] = 2'h0;
      lmsc_pkg::CMD_OSC_START: s[12] = 1'b1;
      lmsc_pkg::CMD_DRIVE_OFF: s[11] = 1'b0;
      lmsc_pkg::CMD_DRIVE_ON: s[11] = 1'b1;
      lmsc_pkg::CMD_FLASH_OFF: s[10] = 1'b0;
      lmsc_pkg::CMD_FLASH_ON: s[10] = 1'b1;
      lmsc_pkg::CMD_FOLLOWER: s[9:6] = 4'h0; // both pins
      lmsc_pkg::CMD_INT_LEADER: s[9:6] = 4'h7; // both pins out
      lmsc_pkg::CMD_EXT_LEADER: s[9:6] = 4'h9; // only timing out
      lmsc_pkg::CMD_CATHODE: s[5:4] = c[3:2];
      lmsc_pkg::CMD_DIMMING: s[3:0] = c[3:0];
      default: ;
    endcase
    return s;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(string what, logic [12:0] seen, logic [12:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait, sampled 1 ns after the edge so the flops have settled
  task automatic wait_high(ref logic s, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      if (s === 1'b1)
        return;
    end
    n_mismatch++;
    $display("[FAIL] handshake expected 1 seen timeout");
    final_report();
  endtask

  // one host request, held until taken, then wait for done
  task automatic xfer(lmsc_pkg::lmsc_kind_e k, logic [6:0] a, logic [3:0] d, logic [8:0] c, logic ch);
    wait_high(req_ready, 50);
    @(posedge clk);
    req_kind <= k;
    req_addr <= a;
    req_data <= d;
    req_cmd <= c;
    req_chain <= ch;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    wait_high(done, 8000);
  endtask

  // read a nibble through the scan port, one link cycle of latency
  task automatic scan_chk(logic [6:0] a);
    @(posedge lclk);
    scan_addr <= a;
    repeat (2) @(posedge lclk);
    #1;
    check("scan nibble", 13'(scan_data), 13'(exp_ram[a]));
  endtask

  // main sequence
  initial
  begin
    logic [6:0] wa [4];
    logic [3:0] wd;
    logic [12:0] cfg;
    logic [8:0] c;
    req_valid = 1'b0;
    req_chain = 1'b0;
    req_kind = lmsc_pkg::KIND_CMD;
    req_addr = 7'h00;
    req_data = 4'h0;
    req_cmd = 9'h000;
    scan_addr = 7'h00;
    rstn = 1'b0;
    rstn_l = 1'b0;
    void'($urandom(32'h428E));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // link reset must see two of its own edges
    repeat (2) @(posedge lclk);
    rstn_l <= 1'b1;
    #1;
    cfg = {lmsc_pkg::RST_OSC_RUN, lmsc_pkg::RST_DISPLAY_RUN, lmsc_pkg::RST_BLINK, lmsc_pkg::RST_CASCADE,
      2'h3, lmsc_pkg::RST_CATHODE, lmsc_pkg::RST_DIM};
    check("reset config", seen_cfg, cfg);
    // one chained command sequence, only the first carries the id
    for (int i = 0; i < 15; i++)
    begin
      c = {CMD_TAB[i][15:8] | (CMD_TAB[i][7:0] & 8'($urandom)), 1'($urandom)};
      xfer(lmsc_pkg::KIND_CMD, 7'h00, 4'h0, c, 1'(i < 14)); // leader and follower both set
      cfg = next_cfg(cfg, c[8:1]);
      repeat (8) @(posedge lclk);
      #1;
      check("config", seen_cfg, cfg);
    end
    $display("test commands done");
    // random single writes, top address included
    for (int i = 0; i < 4; i++)
    begin
      wa[i] = (i == 0) ? 7'h7F : 7'($urandom);
      wd = 4'($urandom);
      xfer(lmsc_pkg::KIND_WRITE, wa[i], wd, 9'h000, 1'b0);
      exp_ram[wa[i]] = wd;
      scan_chk(wa[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      xfer(lmsc_pkg::KIND_READ, wa[i], 4'h0, 9'h000, 1'b0);
      check("read nibble", 13'(rd_data), 13'(exp_ram[wa[i]]));
    end
    $display("test single access done");
    // successive writes across the wrap; the last stays selected
    for (int i = 0; i < 3; i++)
    begin
      wd = 4'($urandom);
      xfer(lmsc_pkg::KIND_WRITE, 7'h7E, wd, 9'h000, 1'b1);
      exp_ram[7'h7E + 7'(i)] = wd;
    end
    for (int i = 0; i < 3; i++)
      scan_chk(7'h7E + 7'(i));
    // kind change forces a fresh select and id
    for (int i = 0; i < 3; i++)
    begin
      xfer(lmsc_pkg::KIND_READ, 7'h7E, 4'h0, 9'h000, 1'(i < 2));
      check("chained read", 13'(rd_data), 13'(exp_ram[7'h7E + 7'(i)]));
    end
    $display("test successive access done");
    // read-modify-write, the second one chained
    for (int i = 0; i < 2; i++)
    begin
      wd = 4'($urandom);
      xfer(lmsc_pkg::KIND_RMW, 7'h7F, wd, 9'h000, 1'(i == 0));
      check("rmw old nibble", 13'(rd_data), 13'(exp_ram[7'h7F + 7'(i)]));
      exp_ram[7'h7F + 7'(i)] = wd;
      scan_chk(7'h7F + 7'(i));
    end
    $display("test read-modify-write done");
    final_report();
  end
endmodule
